// ### include/lcsd_pkg.sv
package lcsd_pkg;
  localparam int unsigned XLEN = 32;
  localparam int unsigned APB_AW = 8;
  localparam int unsigned NREG = 32;

  localparam int unsigned OP_HI = 31;
  localparam int unsigned OP_LO = 26;
  localparam int unsigned FA_HI = 25;
  localparam int unsigned FA_LO = 21;
  localparam int unsigned FB_HI = 20;
  localparam int unsigned FB_LO = 16;
  localparam int unsigned FD_HI = 15;
  localparam int unsigned FD_LO = 11;
  localparam int unsigned PAD_HI = 10;
  localparam int unsigned IMM_HI = 15;
  localparam int unsigned SHA_HI = 4;
  localparam int unsigned GAP_LO = 5;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned HALF_W = 16;

  localparam logic [5:0] OP_OR = 6'h2e;
  localparam logic [5:0] OP_ORI = 6'h0e;
  localparam logic [5:0] OP_ORHI = 6'h1e;
  localparam logic [5:0] OP_XNOR = 6'h29;
  localparam logic [5:0] OP_RCSR = 6'h24;
  localparam logic [5:0] OP_STORE_B = 6'h0c;
  localparam logic [5:0] OP_STORE_H = 6'h03;
  localparam logic [5:0] OP_SEXTB = 6'h2c;
  localparam logic [5:0] OP_SEXTH = 6'h37;
  localparam logic [5:0] OP_SHL = 6'h2f;
  localparam logic [5:0] OP_SLI = 6'h0f;
  localparam logic [31:0] SCALL_WORD = 32'hac000007;

  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [4:0] REG_LINK = 5'h1d;
  localparam logic [4:0] REG_EXC_ADDR = 5'h1e;

  localparam logic [4:0] CSR_IE = 5'h00;
  localparam logic [4:0] CSR_EXC_BASE = 5'h01;
  localparam logic [4:0] CSR_DBG_BASE = 5'h02;
  localparam logic [4:0] CSR_DC = 5'h03;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EXC_BASE = 8'h04;
  localparam logic [7:0] ADDR_DBG_BASE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_GPR_SEL = 8'h14;
  localparam logic [7:0] ADDR_GPR_DATA = 8'h18;

  localparam int unsigned CTRL_IE = 0;
  localparam int unsigned CTRL_SAVED_IE = 1;
  localparam int unsigned CTRL_DVS = 2;
  localparam int unsigned STAT_ILLEGAL = 0;
  localparam int unsigned STAT_BUSY = 1;
  localparam int unsigned STAT_SHPEND = 2;

  localparam logic [31:0] PC_RESET = 32'h00000000;
  localparam logic [31:0] PC_STEP = 32'h00000004;
  localparam logic [31:0] BYTE_MASK = 32'h000000ff;
  localparam int unsigned EXC_STRIDE_LOG2 = 5;
  localparam logic [1:0] MULTI_ISSUE_WAIT = 2'h3;
  localparam logic [1:0] WAIT_LAST = 2'h1;

  typedef enum logic {
    ST_RUN,
    ST_MULTI
  } lcsd_state_t;
endpackage

// ### hw/lcsd_exec.sv
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Complement executes as XNOR with register zero, one-cycle result and issue.
// - Opcode 101110 is register OR, one-cycle result and issue.
// - Opcode 001110 ORs zero-extended 16-bit immediate into destination, one cycle.
// - Opcode 011110 ORs immediate shifted left sixteen, one-cycle latency.
// - Register forms use bits 25..21, 20..16, 15..11; bits 10..0 zero.
// - Immediate logic forms: source 25..21, destination 20..16, immediate 15..0.
// - Opcode 100100 reads CSR indexed by 25..21 into register 15..11.
// - CSR read copies the CSR into the destination, one-cycle result and issue.
// - Return branches to the link register address, four issue cycles.
// - Stores: base 25..21, data 20..16, address base plus signed immediate.
// - Opcode 001100 stores the low data byte at the effective address.
// - Opcode 000011 stores half-word big-endian: high byte first, low byte next.
// - System call is opcode 101011, bits 2..0 set, all others zero.
// - System call saves PC and interrupt enable, clears enable, four issue cycles.
// - Exception target is debug or normal base plus number times 32.
// - Opcode 101100 sign-extends bit 7 into bits 31..8, one cycle.
// - Opcode 110111 sign-extends bit 15 into bits 31..16, one cycle.
// - Sign extensions exist only when the sign extension option is built.
// - Opcode 101111 shifts left by low five bits of operand b, two cycles.
// - Opcode 001111 shifts left by immediate bits 4..0, two cycles.
// - Left shifts exist only when a shifter option is built.
module lcsd_exec #(
  parameter bit SIGN_EXT_OPTION = 1'b1,
  parameter bit MULTICYCLE_SHIFTER_OPTION = 1'b1,
  parameter bit PIPELINED_SHIFTER_OPTION = 1'b0,
  parameter logic [4:0] SCALL_EXC_NUMBER = 5'h02,
  parameter logic [5:0] BRANCH_REG_OPCODE = 6'h30
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lcsd_pkg::APB_AW-1:0] paddr,
  input wire logic [lcsd_pkg::XLEN-1:0] pwdata,
  output logic [lcsd_pkg::XLEN-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [lcsd_pkg::XLEN-1:0] instr_word,
  output logic instr_ready,
  output logic [lcsd_pkg::XLEN-1:0] pc_out,
  output logic store_valid,
  output logic [lcsd_pkg::XLEN-1:0] store_addr,
  output logic [lcsd_pkg::BYTE_W-1:0] store_byte0,
  output logic [lcsd_pkg::BYTE_W-1:0] store_byte1,
  output logic store_two,
  output logic exc_taken
);
  import lcsd_pkg::*;

  if (PIPELINED_SHIFTER_OPTION && MULTICYCLE_SHIFTER_OPTION) begin : g_chk
    $error("Only one shifter option may be selected.");
  end

  logic [XLEN-1:0] gpr_r [NREG];
  logic [XLEN-1:0] pc_r;
  logic ie_r;
  logic saved_ie_r;
  logic dvs_r;
  logic [XLEN-1:0] exc_base_r;
  logic [XLEN-1:0] dbg_base_r;
  logic illegal_r;
  logic [4:0] gpr_sel_r;
  lcsd_state_t state_r;
  logic [1:0] wait_r;
  logic ready_r;
  logic shf_pend_r;
  logic [4:0] shf_rd_r;
  logic [XLEN-1:0] shf_val_r;
  logic [4:0] shf_amt_r;
  logic st_valid_r;
  logic [XLEN-1:0] st_addr_r;
  logic [BYTE_W-1:0] st_b0_r;
  logic [BYTE_W-1:0] st_b1_r;
  logic st_two_r;
  logic exc_r;
  logic [XLEN-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // Instruction fields.
  wire [5:0] opcode = instr_word[OP_HI:OP_LO];
  wire [4:0] fld_a = instr_word[FA_HI:FA_LO];
  wire [4:0] fld_b = instr_word[FB_HI:FB_LO];
  wire [4:0] fld_d = instr_word[FD_HI:FD_LO];
  wire [HALF_W-1:0] imm_fld = instr_word[IMM_HI:0];
  wire [4:0] shamt_fld = instr_word[SHA_HI:0];
  wire pad_zero = (instr_word[PAD_HI:0] == '0);
  wire gap_zero = (instr_word[IMM_HI:GAP_LO] == '0);
  wire b_zero = (fld_b == REG_ZERO);
  wire shift_built = MULTICYCLE_SHIFTER_OPTION || PIPELINED_SHIFTER_OPTION;

  // A pending shift result is forwarded to any instruction that reads its destination; the APB register read is not.
  // The shift lands in the register file one edge late, so without this
  // path the instruction right behind it would read a stale value.
  wire [XLEN-1:0] shf_result = shf_val_r << shf_amt_r;
  wire fwd_a = shf_pend_r && (shf_rd_r == fld_a);
  wire fwd_b = shf_pend_r && (shf_rd_r == fld_b);
  wire fwd_l = shf_pend_r && (shf_rd_r == REG_LINK);
  wire [XLEN-1:0] val_a = (fld_a == REG_ZERO) ? '0 : (fwd_a ? shf_result : gpr_r[fld_a]);
  wire [XLEN-1:0] val_b = (fld_b == REG_ZERO) ? '0 : (fwd_b ? shf_result : gpr_r[fld_b]);
  wire [XLEN-1:0] val_link = fwd_l ? shf_result : gpr_r[REG_LINK];

  // Decode.
  wire is_or = (opcode == OP_OR) && pad_zero;
  wire is_xnor = (opcode == OP_XNOR) && pad_zero;
  wire is_ori = (opcode == OP_ORI);
  wire is_orhi = (opcode == OP_ORHI);
  wire is_rcsr = (opcode == OP_RCSR) && b_zero && pad_zero;
  wire is_ret = (opcode == BRANCH_REG_OPCODE) && (fld_a == REG_LINK)
                && (instr_word[FB_HI:0] == '0);
  wire is_stb = (opcode == OP_STORE_B);
  wire is_sth = (opcode == OP_STORE_H);
  wire is_scall = (instr_word == SCALL_WORD);
  // An opcode whose unit is not built decodes as unknown, so it only
  // advances the program counter and raises the illegal flag.
  wire is_sextb = SIGN_EXT_OPTION && (opcode == OP_SEXTB) && b_zero && pad_zero;
  wire is_sexth = SIGN_EXT_OPTION && (opcode == OP_SEXTH) && b_zero && pad_zero;
  wire is_shl = shift_built && (opcode == OP_SHL) && pad_zero;
  wire is_sli = shift_built && (opcode == OP_SLI) && gap_zero;

  wire accept = instr_valid && ready_r;
  wire one_cycle = is_or || is_xnor || is_ori || is_orhi || is_rcsr || is_sextb || is_sexth;
  wire is_shift = is_shl || is_sli;
  wire is_store = is_stb || is_sth;
  wire is_multi = is_ret || is_scall;
  wire known = one_cycle || is_shift || is_store || is_multi;

  // One-cycle results.
  wire [XLEN-1:0] imm_zext = {{(XLEN-HALF_W){1'b0}}, imm_fld};
  wire [XLEN-1:0] imm_sext = {{(XLEN-HALF_W){imm_fld[HALF_W-1]}}, imm_fld};
  wire [XLEN-1:0] imm_high = {imm_fld, {HALF_W{1'b0}}};
  // Control register read; indices with no register behind them read as zero.
  wire [XLEN-1:0] csr_val =
    (fld_a == CSR_IE) ? {{(XLEN-2){1'b0}}, saved_ie_r, ie_r} :
    (fld_a == CSR_EXC_BASE) ? exc_base_r :
    (fld_a == CSR_DBG_BASE) ? dbg_base_r :
    (fld_a == CSR_DC) ? {{(XLEN-1){1'b0}}, dvs_r} : '0;
  wire [XLEN-1:0] res_or = val_a | val_b;
  wire [XLEN-1:0] res_xnor = ~(val_a ^ val_b);
  wire [XLEN-1:0] res_ori = val_a | imm_zext;
  wire [XLEN-1:0] res_orhi = val_a | imm_high;
  wire [XLEN-1:0] res_sextb = {{(XLEN-BYTE_W){val_a[BYTE_W-1]}}, val_a[BYTE_W-1:0]};
  wire [XLEN-1:0] res_sexth = {{(XLEN-HALF_W){val_a[HALF_W-1]}}, val_a[HALF_W-1:0]};
  wire [XLEN-1:0] res_one =
    is_or ? res_or :
    is_xnor ? res_xnor :
    is_ori ? res_ori :
    is_orhi ? res_orhi :
    is_rcsr ? csr_val :
    is_sextb ? res_sextb : res_sexth;
  wire use_fd = is_or || is_xnor || is_rcsr || is_sextb || is_sexth || is_shl;
  wire [4:0] dest = use_fd ? fld_d : fld_b;
  wire wr_one = accept && one_cycle && (dest != REG_ZERO);

  // Stores and exceptions.
  wire [XLEN-1:0] eff_addr = val_a + imm_sext;
  wire [XLEN-1:0] lo_byte = val_b & BYTE_MASK;
  wire [BYTE_W-1:0] st_b0 = is_sth ? val_b[HALF_W-1:BYTE_W] : lo_byte[BYTE_W-1:0];
  wire [XLEN-1:0] vec_base = dvs_r ? dbg_base_r : exc_base_r;
  // The system call is the only exception source here, so its offset is fixed.
  wire [XLEN-1:0] vec_off = {{(XLEN-5){1'b0}}, SCALL_EXC_NUMBER} << EXC_STRIDE_LOG2;
  wire [XLEN-1:0] exc_target = vec_base + vec_off;
  wire [4:0] shf_amt = is_shl ? val_b[4:0] : shamt_fld;

  // APB decode.
  wire apb_acc = psel && penable;
  wire apb_wr = apb_acc && pwrite && pready_r;
  wire a_ctrl = (paddr == ADDR_CTRL);
  wire a_exc_base = (paddr == ADDR_EXC_BASE);
  wire a_dbg_base = (paddr == ADDR_DBG_BASE);
  wire a_stat = (paddr == ADDR_STATUS);
  wire a_pc = (paddr == ADDR_PC);
  wire a_sel = (paddr == ADDR_GPR_SEL);
  wire a_gdat = (paddr == ADDR_GPR_DATA);
  // An unmapped offset answers with an error and changes nothing, so a bad
  // pointer in software cannot disturb the core's state.
  wire a_hit = a_ctrl || a_exc_base || a_dbg_base || a_stat || a_pc || a_sel || a_gdat;
  wire [XLEN-1:0] ctrl_rd = {{(XLEN-3){1'b0}}, dvs_r, saved_ie_r, ie_r};
  wire [XLEN-1:0] stat_rd = {{(XLEN-3){1'b0}}, shf_pend_r, !ready_r, illegal_r};
  wire [XLEN-1:0] rd_mux =
    a_ctrl ? ctrl_rd :
    a_exc_base ? exc_base_r :
    a_dbg_base ? dbg_base_r :
    a_stat ? stat_rd :
    a_pc ? pc_r :
    a_sel ? {{(XLEN-5){1'b0}}, gpr_sel_r} :
    a_gdat ? gpr_r[gpr_sel_r] : '0;
  wire sw_gpr_wr = apb_wr && a_gdat && (gpr_sel_r != REG_ZERO);

  // Register file: a shift retiring now, then the newer one-cycle result,
  // then software preload; the later write wins on a clash.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NREG; i++) begin
        gpr_r[i] <= '0;
      end
    end else begin
      if (shf_pend_r && shf_rd_r != REG_ZERO) begin
        gpr_r[shf_rd_r] <= shf_result;
      end
      if (wr_one) begin
        gpr_r[dest] <= res_one;
      end
      if (accept && is_scall) begin
        gpr_r[REG_EXC_ADDR] <= pc_r;
      end
      if (sw_gpr_wr) begin
        gpr_r[gpr_sel_r] <= pwdata;
      end
    end
  end

  // Shifter stage: operands are latched at issue, result written one edge later.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shf_pend_r <= 1'b0;
      shf_rd_r <= REG_ZERO;
      shf_val_r <= '0;
      shf_amt_r <= '0;
    end else begin
      shf_pend_r <= accept && is_shift;
      shf_rd_r <= dest;
      shf_val_r <= val_a;
      shf_amt_r <= shf_amt;
    end
  end

  // Issue control: return and system call hold off the next instruction.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_RUN;
      wait_r <= '0;
      ready_r <= 1'b1;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (accept && is_multi) begin
            state_r <= ST_MULTI;
            wait_r <= MULTI_ISSUE_WAIT;
            ready_r <= 1'b0;
          end
        end
        ST_MULTI: begin
          wait_r <= wait_r - WAIT_LAST;
          if (wait_r == WAIT_LAST) begin
            state_r <= ST_RUN;
            ready_r <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_RUN;
          ready_r <= 1'b1;
        end
      endcase
    end
  end

  // Program counter; a software write overrides instruction flow.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pc_r <= PC_RESET;
    end else if (apb_wr && a_pc) begin
      pc_r <= pwdata;
    end else if (accept) begin
      if (is_ret) begin
        pc_r <= val_link;
      end else if (is_scall) begin
        pc_r <= exc_target;
      end else begin
        pc_r <= pc_r + PC_STEP;
      end
    end
  end

  // Control and status state.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ie_r <= 1'b0;
      saved_ie_r <= 1'b0;
      dvs_r <= 1'b0;
      exc_base_r <= '0;
      dbg_base_r <= '0;
      illegal_r <= 1'b0;
      gpr_sel_r <= '0;
    end else begin
      if (apb_wr && a_ctrl) begin
        ie_r <= pwdata[CTRL_IE];
        saved_ie_r <= pwdata[CTRL_SAVED_IE];
        dvs_r <= pwdata[CTRL_DVS];
      end
      // A system call on the same edge as a control write wins, and it saves
      // the enable as it stood before that edge.
      if (accept && is_scall) begin
        saved_ie_r <= ie_r;
        ie_r <= 1'b0;
      end
      if (apb_wr && a_exc_base) begin
        exc_base_r <= pwdata;
      end
      if (apb_wr && a_dbg_base) begin
        dbg_base_r <= pwdata;
      end
      if (apb_wr && a_sel) begin
        gpr_sel_r <= pwdata[4:0];
      end
      // Set wins over the write-one clear.
      if (accept && !known) begin
        illegal_r <= 1'b1;
      end else if (apb_wr && a_stat && pwdata[STAT_ILLEGAL]) begin
        illegal_r <= 1'b0;
      end
    end
  end

  // Store port and exception pulse.
  // Address and bytes stay put until the next store, so memory may take them late.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_valid_r <= 1'b0;
      st_addr_r <= '0;
      st_b0_r <= '0;
      st_b1_r <= '0;
      st_two_r <= 1'b0;
      exc_r <= 1'b0;
    end else begin
      st_valid_r <= accept && is_store;
      exc_r <= accept && is_scall;
      if (accept && is_store) begin
        st_addr_r <= eff_addr;
        st_b0_r <= st_b0;
        st_b1_r <= val_b[BYTE_W-1:0];
        st_two_r <= is_sth;
      end
    end
  end

  // APB slave: ready rises one cycle into the access phase.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= apb_acc && !pready_r;
      if (apb_acc && !pready_r) begin
        pslverr_r <= !a_hit;
        prdata_r <= pwrite ? '0 : rd_mux;
      end else begin
        pslverr_r <= 1'b0;
        prdata_r <= '0;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign instr_ready = ready_r;
  assign pc_out = pc_r;
  assign store_valid = st_valid_r;
  assign store_addr = st_addr_r;
  assign store_byte0 = st_b0_r;
  assign store_byte1 = st_b1_r;
  assign store_two = st_two_r;
  assign exc_taken = exc_r;
endmodule

// ### testbench/lcsd_exec_monitor.sv
`timescale 1ns/10ps
module lcsd_exec_monitor #(
  parameter logic [5:0] BRANCH_REG_OPCODE = 6'h30
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lcsd_pkg::APB_AW-1:0] paddr,
  input wire logic pready,
  input wire logic instr_valid,
  input wire logic [lcsd_pkg::XLEN-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic [lcsd_pkg::XLEN-1:0] pc_out,
  input wire logic store_valid,
  input wire logic store_two,
  input wire logic exc_taken
);
  import lcsd_pkg::*;
  wire logic take = instr_valid && instr_ready;
  wire logic [5:0] op = instr_word[31:26];
  wire logic is_st = op == OP_STORE_B || op == OP_STORE_H;
  wire logic is_sth = op == OP_STORE_H;
  wire logic is_scall = instr_word == SCALL_WORD;
  wire logic is_ret = instr_word == {BRANCH_REG_OPCODE, REG_LINK, 21'h0};
  wire logic pc_wr = psel && penable && pready && pwrite && paddr == ADDR_PC;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_store_cause: assert property (store_valid |-> $past(take) && $past(is_st))
    else $error("store pulse without a store instruction");
  chk_half_flag: assert property (store_valid |-> store_two == $past(is_sth))
    else $error("store width flag wrong");
  chk_scall_exc: assert property (take && is_scall |=> exc_taken)
    else $error("system call did not raise an exception");
  chk_exc_cause: assert property (exc_taken |-> $past(take) && $past(is_scall))
    else $error("exception without a system call");
  chk_scall_issue: assert property (
    take && is_scall |=> !instr_ready [*3] ##1 instr_ready)
    else $error("system call issue time wrong");
  chk_ret_issue: assert property (
    take && is_ret |=> !instr_ready [*3] ##1 instr_ready)
    else $error("return issue time wrong");
  chk_or_step: assert property (
    take && op == OP_OR && !pc_wr |=> instr_ready && pc_out == $past(pc_out) + PC_STEP)
    else $error("register or did not issue in one cycle");
  chk_shift_issue: assert property (
    take && (op == OP_SHL || op == OP_SLI) |=> instr_ready)
    else $error("shift did not issue in one cycle");
endmodule
bind lcsd_exec lcsd_exec_monitor #(.BRANCH_REG_OPCODE(BRANCH_REG_OPCODE)) u_mon (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready(instr_ready), .pc_out(pc_out), .store_valid(store_valid),
  .store_two(store_two), .exc_taken(exc_taken));

// ### testbench/lcsd_exec_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module lcsd_exec_tb;
  import lcsd_pkg::*;
  localparam logic [4:0] EXC_NUM = 5'h03;
  localparam logic [5:0] BR_OP = 6'h30;
  logic ref_clk, resetn, psel, penable, pwrite, instr_valid, er;
  logic pready, pslverr, instr_ready, store_valid, store_two, exc_taken;
  logic [7:0] paddr, store_byte0, store_byte1;
  logic [31:0] pwdata, prdata, instr_word, pc_out, store_addr, rd, w, seed_v;
  logic [31:0] prdata_m, rd_m;
  logic [31:0] gm [32];
  logic [31:0] csr_exp [4];
  logic [5:0] ops [8];
  logic [4:0] a, b, d;
  logic [15:0] imm;
  int failures = 0;
  int n_checks = 0;
  lcsd_exec #(.SCALL_EXC_NUMBER(EXC_NUM), .BRANCH_REG_OPCODE(BR_OP)) dut (.ref_clk, .resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_valid,
    .instr_word, .instr_ready, .pc_out, .store_valid, .store_addr, .store_byte0,
    .store_byte1, .store_two, .exc_taken);
  // A copy built without the optional units must refuse their opcodes.
  lcsd_exec #(.SIGN_EXT_OPTION(1'b0), .MULTICYCLE_SHIFTER_OPTION(1'b0),
    .SCALL_EXC_NUMBER(EXC_NUM), .BRANCH_REG_OPCODE(BR_OP)) dut_min (.ref_clk, .resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(prdata_m), .pready(), .pslverr(),
    .instr_valid, .instr_word, .instr_ready(), .pc_out(), .store_valid(), .store_addr(),
    .store_byte0(), .store_byte1(), .store_two(), .exc_taken());
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    rd_m = prdata_m;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic ins(input logic [31:0] iw, input bit last);
    int n;
    n = 0;
    instr_valid <= 1;
    instr_word <= iw;
    do begin
      @(posedge ref_clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 20);
    if (instr_ready !== 1'b1) failures++;
    if (last) instr_valid <= 0;
  endtask
  task automatic setg(input logic [4:0] r, input logic [31:0] v);
    apb(1, ADDR_GPR_SEL, {27'h0, r});
    apb(1, ADDR_GPR_DATA, v);
    if (r != REG_ZERO) gm[r] = v;
  endtask
  task automatic getg(input logic [4:0] r);
    apb(1, ADDR_GPR_SEL, {27'h0, r});
    apb(0, ADDR_GPR_DATA, 32'h0);
  endtask
  function automatic logic [31:0] res(input logic [31:0] iw);
    logic [31:0] x, y;
    x = gm[iw[25:21]];
    y = gm[iw[20:16]];
    case (iw[31:26])
      OP_OR: return x | y;
      OP_ORI: return x | {16'h0, iw[15:0]};
      OP_ORHI: return x | {iw[15:0], 16'h0};
      OP_XNOR: return ~(x ^ y);
      OP_SEXTB: return {{24{x[7]}}, x[7:0]};
      OP_SEXTH: return {{16{x[15]}}, x[15:0]};
      OP_SHL: return x << y[4:0];
      default: return x << iw[4:0];
    endcase
  endfunction
  task automatic run(input logic [31:0] iw, input bit last);
    logic [4:0] dr;
    dr = (iw[31:26] inside {OP_ORI, OP_ORHI, OP_SLI}) ? iw[20:16] : iw[15:11];
    gm[dr] = res(iw);
    ins(iw, last);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim();
  end
  initial begin
    resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    instr_valid = 0; instr_word = 0;
    foreach (gm[i]) gm[i] = 32'h0;
    ops = '{OP_OR, OP_ORI, OP_ORHI, OP_XNOR, OP_SEXTB, OP_SEXTH, OP_SHL, OP_SLI};
    csr_exp = '{32'h1, 32'h1000, 32'h2000, 32'h1};
    seed_v = $urandom(32'h6565530c);
    repeat (10) @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    `CHK(pc_out, PC_RESET)
    for (int i = 1; i < 29; i++) setg(i[4:0], $urandom);
    setg(REG_ZERO, 32'hffffffff);
    getg(REG_ZERO);
    `CHK(rd, 32'h0)
    for (int k = 0; k < 24; k++) begin
      a = 5'($urandom_range(28));
      b = 5'($urandom_range(28));
      d = 5'($urandom_range(28, 1));
      imm = 16'($urandom);
      case (ops[k % 8])
        OP_ORI, OP_ORHI: w = {ops[k % 8], a, d, imm};
        OP_SLI: w = {OP_SLI, a, d, 11'h0, imm[4:0]};
        OP_XNOR, OP_SEXTB, OP_SEXTH: w = {ops[k % 8], a, 5'h0, d, 11'h0};
        default: w = {ops[k % 8], a, b, d, 11'h0};
      endcase
      run(w, 1);
      getg(d);
      `CHK(rd, gm[d])
    end
    run({OP_SHL, 5'd1, 5'd2, 5'd7, 11'h0}, 0);
    run({OP_OR, 5'd7, 5'd0, 5'd8, 11'h0}, 1);
    getg(5'd8);
    `CHK(rd, gm[8])
    apb(1, ADDR_EXC_BASE, 32'h1000);
    apb(1, ADDR_DBG_BASE, 32'h2000);
    apb(1, ADDR_CTRL, 32'h5);
    for (int c = 0; c < 4; c++) begin
      ins({OP_RCSR, c[4:0], 5'h0, 5'd9, 11'h0}, 1);
      gm[9] = csr_exp[c];
      getg(5'd9);
      `CHK(rd, gm[9])
    end
    for (int s = 0; s < 2; s++) begin
      apb(1, ADDR_CTRL, s ? 32'h1 : 32'h5);
      apb(1, ADDR_PC, 32'h100);
      ins(SCALL_WORD, 1);
      @(posedge ref_clk);
      `CHK(exc_taken, 1'b1)
      `CHK(pc_out, (s ? 32'h1000 : 32'h2000) + 32'({EXC_NUM, 5'h0}))
      gm[30] = 32'h100;
      getg(REG_EXC_ADDR);
      `CHK(rd, gm[30])
      apb(0, ADDR_CTRL, 32'h0);
      `CHK(rd, s ? 32'h2 : 32'h6)
    end
    setg(REG_LINK, $urandom & 32'hfffffffc);
    ins({BR_OP, REG_LINK, 21'h0}, 1);
    @(posedge ref_clk);
    `CHK(pc_out, gm[29])
    for (int s = 0; s < 4; s++) begin
      imm = 16'($urandom);
      ins({s[0] ? OP_STORE_H : OP_STORE_B, 5'd3, 5'd4, imm}, 1);
      @(posedge ref_clk);
      `CHK(store_valid, 1'b1)
      `CHK(store_two, s[0])
      `CHK(store_addr, gm[3] + {{16{imm[15]}}, imm})
      `CHK(store_byte0, s[0] ? gm[4][15:8] : gm[4][7:0])
      if (s[0]) `CHK(store_byte1, gm[4][7:0])
    end
    apb(1, ADDR_STATUS, 32'h1);
    ins(SCALL_WORD | 32'h8, 1);
    @(posedge ref_clk);
    `CHK(exc_taken, 1'b0)
    apb(0, ADDR_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
    apb(1, ADDR_STATUS, 32'h1);
    apb(0, ADDR_STATUS, 32'h0);
    `CHK(rd[0], 1'b0)
    ins({OP_SEXTB, 5'd1, 5'h0, 5'd10, 11'h0}, 1);
    apb(0, ADDR_STATUS, 32'h0);
    `CHK(rd[0], 1'b0)
    `CHK(rd_m[0], 1'b1)
    apb(1, ADDR_STATUS, 32'h1);
    ins({OP_SHL, 5'd1, 5'd2, 5'd11, 11'h0}, 1);
    apb(0, ADDR_STATUS, 32'h0);
    `CHK(rd[0], 1'b0)
    `CHK(rd_m[0], 1'b1)
    apb(0, 8'h40, 32'h0);
    `CHK(er, 1'b1)
    end_sim();
  end
endmodule
